// ### tdc_pkg.sv
// Package for the 8-bit event/capture timer: register map, field layout, timing.
// Assumes a 50 MHz system clock standing in for the instruction cycle.
package tdc_pkg;
	localparam logic [11:0] IDX_MODE1 = 12'h010;
	localparam logic [11:0] IDX_CNT_LO = 12'h011;
	localparam logic [11:0] IDX_CNT_HI = 12'h012;
	localparam logic [11:0] IDX_MODE2 = 12'h015;
	localparam logic [11:0] IDX_PINSEL = 12'h025;
	localparam logic [11:0] IDX_EDGE = 12'h027;
	localparam logic [11:0] IDX_FLAGS = 12'h021;
	localparam logic [11:0] IDX_CTRL = 12'h030;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam int MODE1_RELOAD_BIT = 3;
	localparam logic [2:0] CLK_EVENT = 3'h7;
	localparam int MODE2_CAPTURE_BIT = 3;
	localparam logic [3:0] OUT_PORT = 4'h0;
	localparam logic [3:0] OUT_TOGGLE = 4'h1;
	localparam logic [3:0] OUT_LOW = 4'h2;
	localparam logic [3:0] OUT_HIGH = 4'h3;
	localparam logic [3:0] OUT_PWM = 4'h7;
	localparam int PIN_EVENT_BIT = 1;
	localparam int EDGE_FALL_BIT = 2;
	localparam int EDGE_RISE_BIT = 3;
	localparam int FLAG_IRQ_BIT = 0;
	localparam int FLAG_CSF_BIT = 1;
	localparam int FLAG_CEF_BIT = 2;
	localparam int CTRL_STOP_BIT = 0;
	localparam int CTRL_PORT_BIT = 1;
	localparam logic [1:0] MODE1_HOLD = 2'h2;
	localparam logic [10:0] PRESC_MAX = 11'h7FF;
endpackage

// ### tdc_timer.sv
// 8-bit timer/event counter/input capture with an APB register slave.
// Assumes an APB master on SYS_CLK; the event pin is asynchronous.
// Behaviour
// R1: Software loads counter from write register; it counts up one per input clock.
// R2: Input clock at FF signals overflow; reload mode reloads from write register.
// R3: Free-running overflow returns count to 00 and keeps counting.
// R4: Interrupt flag clears by software write, reset and stop mode.
// R5: Clock select 111 counts external events, otherwise timer behaviour.
// R6: Events count on falling, rising or both edges as selected.
// R7: Source keeps each level two cycles when both edges are used.
// R8: Output mode decode: port, toggle, low, high, PWM; top bit capture.
// R9: Toggle inverts per overflow; PWM pulse width follows reload value.
// R10: Capture measures internal clocks between selected trigger edges.
// R11: Trigger copies count to read register, sets flags, clears count.
// R12: Trigger or overflow while capture status set sets capture error.
// R13: Capture status and error clear on reset or software writing 0.
// R14: Selecting capture forces the pin to port and clears counter.
// R15: First mode register is 4-bit write-only, cleared by reset and stop.
// R16: Mode1 writes take effect two cycles apart; load count afterwards.
// R17: Software picks internal clock for capture, sets pin enable for events.
// R18: Mode1 bit 3 reload, bits 2-0 pick period 2048 down to 2 or events.
// R19: Second mode register is 4-bit read/write, cleared by reset and stop.
// R20: Upper load nibble undefined after reset until written.
// R21: Low nibble write leaves counter; high write loads both nibbles.
// R22: Reading high returns live high and latches live low for low read.
// R23: After a capture, low and high nibbles read in either order.
`timescale 1ns/1ns
module tdc_timer (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [11:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic EVENT_TRIGGER_PIN,
	output logic TIMER_OUTPUT_PIN,
	output logic TIMER_OUTPUT_EN,
	output logic TIMER_IRQ_FLAG
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] mode1;
		logic [3:0] mode1_pend;
		logic pend_valid;
		logic [1:0] hold;
		logic [3:0] mode2;
		logic [3:0] pinsel;
		logic [3:0] edge_sel;
		logic [3:0] load_lo;
		logic [3:0] load_hi;
		logic [7:0] cnt;
		logic [7:0] rd;
		logic [3:0] rd_lo_latch;
		logic cap_valid;
		logic [10:0] presc;
		logic ev_s1;
		logic ev_s2;
		logic ev_s3;
		logic irq;
		logic csf;
		logic cef;
		logic stop;
		logic port_level;
		logic tout;
		logic toe;
	} tdc_state_s;

	tdc_state_s st_reg;
	tdc_state_s st_next;
	logic acc;
	logic wr;
	logic irq_set;
	logic cap_set;
	logic err_set;
	logic rise;
	logic fall;
	logic edge_hit;
	logic tick;
	logic ovf;
	logic cap_mode;
	logic [3:0] wnib;

	always_comb begin
		st_next = st_reg;
		acc = PSEL && PENABLE && st_reg.pready;
		wr = acc && PWRITE;
		wnib = PWDATA[3:0];
		cap_mode = st_reg.mode2[tdc_pkg::MODE2_CAPTURE_BIT]; // R8
		rise = st_reg.ev_s2 && !st_reg.ev_s3;
		fall = !st_reg.ev_s2 && st_reg.ev_s3;
		edge_hit = (rise && st_reg.edge_sel[tdc_pkg::EDGE_RISE_BIT])
			|| (fall && st_reg.edge_sel[tdc_pkg::EDGE_FALL_BIT]); // R6 R10
		// Synchroniser, first stage read only by the second
		st_next.ev_s1 = EVENT_TRIGGER_PIN;
		st_next.ev_s2 = st_reg.ev_s1;
		st_next.ev_s3 = st_reg.ev_s2;
		// Prescaler
		st_next.presc = st_reg.presc + 11'h001;
		tick = 1'b0;
		unique case (st_reg.mode1[2:0]) // R18
			3'h0: tick = (st_reg.presc == tdc_pkg::PRESC_MAX);
			3'h1: tick = (st_reg.presc[8:0] == tdc_pkg::PRESC_MAX[8:0]);
			3'h2: tick = (st_reg.presc[6:0] == tdc_pkg::PRESC_MAX[6:0]);
			3'h3: tick = (st_reg.presc[4:0] == tdc_pkg::PRESC_MAX[4:0]);
			3'h4: tick = (st_reg.presc[2:0] == tdc_pkg::PRESC_MAX[2:0]);
			3'h5: tick = (st_reg.presc[1:0] == tdc_pkg::PRESC_MAX[1:0]);
			3'h6: tick = st_reg.presc[0];
			3'h7: tick = edge_hit && st_reg.pinsel[tdc_pkg::PIN_EVENT_BIT] && !cap_mode; // R5 R17
		endcase
		ovf = tick && (st_reg.cnt == tdc_pkg::CNT_MAX); // R2
		// Hardware set events, these win over a software clear
		irq_set = (cap_mode && edge_hit) || (!cap_mode && ovf);
		cap_set = cap_mode && edge_hit;
		err_set = cap_mode && st_reg.csf && (edge_hit || ovf);
		// Counter
		if (tick) begin
			if (ovf && st_reg.mode1[tdc_pkg::MODE1_RELOAD_BIT]) begin
				st_next.cnt = {st_reg.load_hi, st_reg.load_lo}; // R2
			end else begin
				st_next.cnt = st_reg.cnt + 8'h01; // R1 R3
			end
		end
		if (cap_mode && edge_hit) begin
			st_next.rd = st_reg.cnt; // R11
			st_next.cap_valid = 1'b1; // R23
			st_next.cnt = tick ? 8'h01 : tdc_pkg::CNT_ZERO; // R11
			st_next.irq = 1'b1;
			st_next.csf = 1'b1;
		end
		if (cap_mode && st_reg.csf && (edge_hit || ovf)) begin
			st_next.cef = 1'b1; // R12
		end
		if (!cap_mode && ovf) begin
			st_next.irq = 1'b1;
		end
		// Output pin
		unique case (st_reg.mode2)
			tdc_pkg::OUT_TOGGLE: begin
				if (ovf) begin
					st_next.tout = !st_reg.tout; // R9
				end
				st_next.toe = 1'b1;
			end
			tdc_pkg::OUT_LOW: begin
				st_next.tout = 1'b0;
				st_next.toe = 1'b1;
			end
			tdc_pkg::OUT_HIGH: begin
				st_next.tout = 1'b1;
				st_next.toe = 1'b1;
			end
			tdc_pkg::OUT_PWM: begin
				// Low from reload until FF, high for the last count
				st_next.tout = (st_next.cnt == tdc_pkg::CNT_MAX); // R9
				st_next.toe = 1'b1;
			end
			default: begin
				st_next.tout = st_reg.port_level; // R8 R14
				st_next.toe = 1'b0;
			end
		endcase
		// Mode1 write spacing
		if (st_reg.hold != 2'h0) begin
			st_next.hold = st_reg.hold - 2'h1;
		end
		if (st_reg.pend_valid && st_reg.hold == 2'h0) begin
			st_next.mode1 = st_reg.mode1_pend; // R16
			st_next.pend_valid = 1'b0;
			st_next.hold = tdc_pkg::MODE1_HOLD;
		end
		// APB
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		if (PSEL && !PENABLE) begin
			st_next.pready = 1'b1;
		end
		if (wr) begin
			unique case (PADDR[11:2])
				tdc_pkg::IDX_MODE1[9:0]: begin
					if (st_reg.hold == 2'h0 && !st_reg.pend_valid) begin
						st_next.mode1 = wnib; // R15
						st_next.hold = tdc_pkg::MODE1_HOLD; // R16
					end else begin
						st_next.mode1_pend = wnib; // R16
						st_next.pend_valid = 1'b1;
					end
				end
				tdc_pkg::IDX_CNT_LO[9:0]: st_next.load_lo = wnib; // R21
				tdc_pkg::IDX_CNT_HI[9:0]: begin
					st_next.load_hi = wnib; // R20
					st_next.cnt = {wnib, st_reg.load_lo}; // R1 R21
				end
				tdc_pkg::IDX_MODE2[9:0]: begin
					st_next.mode2 = wnib; // R19
					if (wnib[tdc_pkg::MODE2_CAPTURE_BIT] && !cap_mode) begin
						st_next.cnt = tdc_pkg::CNT_ZERO; // R14
					end
				end
				tdc_pkg::IDX_PINSEL[9:0]: st_next.pinsel = wnib;
				tdc_pkg::IDX_EDGE[9:0]: st_next.edge_sel = wnib;
				tdc_pkg::IDX_FLAGS[9:0]: begin
					if (!wnib[tdc_pkg::FLAG_IRQ_BIT] && !irq_set) begin
						st_next.irq = 1'b0; // R4
					end
					if (!wnib[tdc_pkg::FLAG_CSF_BIT] && !cap_set) begin
						st_next.csf = 1'b0; // R13
					end
					if (!wnib[tdc_pkg::FLAG_CEF_BIT] && !err_set) begin
						st_next.cef = 1'b0; // R13
					end
				end
				tdc_pkg::IDX_CTRL[9:0]: begin
					st_next.stop = wnib[tdc_pkg::CTRL_STOP_BIT];
					st_next.port_level = wnib[tdc_pkg::CTRL_PORT_BIT];
				end
				default: ;
			endcase
		end
		if (PSEL && !PENABLE) begin
			st_next.prdata = '0;
			unique case (PADDR[11:2])
				tdc_pkg::IDX_CNT_LO[9:0]: st_next.prdata[3:0] = st_reg.cap_valid ? st_reg.rd[3:0]
					: st_reg.rd_lo_latch; // R22 R23
				tdc_pkg::IDX_CNT_HI[9:0]: st_next.prdata[3:0] = st_reg.cap_valid ? st_reg.rd[7:4]
					: st_reg.cnt[7:4]; // R22 R23
				tdc_pkg::IDX_MODE2[9:0]: st_next.prdata[3:0] = st_reg.mode2;
				tdc_pkg::IDX_FLAGS[9:0]: st_next.prdata[2:0] = {st_reg.cef, st_reg.csf, st_reg.irq};
				tdc_pkg::IDX_CTRL[9:0]: st_next.prdata[1:0] = {st_reg.port_level, st_reg.stop};
				tdc_pkg::IDX_MODE1[9:0], tdc_pkg::IDX_PINSEL[9:0], tdc_pkg::IDX_EDGE[9:0]: st_next.prdata = '0;
				default: st_next.pslverr = 1'b1;
			endcase
		end
		if (PSEL && !PENABLE && !PWRITE && PADDR[11:2] == tdc_pkg::IDX_CNT_HI[9:0] && !st_reg.cap_valid) begin
			st_next.rd_lo_latch = st_reg.cnt[3:0]; // R22
		end
		if (!cap_mode) begin
			st_next.cap_valid = 1'b0;
		end
		if (st_reg.stop) begin
			st_next.mode1 = tdc_pkg::NIB_ZERO; // R15
			st_next.mode2 = tdc_pkg::NIB_ZERO; // R19
			st_next.pend_valid = 1'b0;
			st_next.irq = 1'b0; // R4
			st_next.edge_sel = tdc_pkg::NIB_ZERO;
			st_next.load_lo = tdc_pkg::NIB_ZERO;
			st_next.pinsel[tdc_pkg::PIN_EVENT_BIT] = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			st_reg <= '0; // R4 R13 R15 R19
		end else begin
			st_reg <= st_next;
		end
	end

	assign PRDATA = st_reg.prdata;
	assign PREADY = st_reg.pready;
	assign PSLVERR = st_reg.pslverr;
	assign TIMER_OUTPUT_PIN = st_reg.tout;
	assign TIMER_OUTPUT_EN = st_reg.toe;
	assign TIMER_IRQ_FLAG = st_reg.irq;

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	// Counter checks
	reload_value_a: assert property ( // R2
		ovf && st_reg.mode1[tdc_pkg::MODE1_RELOAD_BIT] && !cap_mode && !wr
		|=> st_reg.cnt == {st_reg.load_hi, st_reg.load_lo})
		else $error("reload lost");
	free_wrap_a: assert property ( // R3
		ovf && !st_reg.mode1[tdc_pkg::MODE1_RELOAD_BIT] && !cap_mode && !wr
		|=> st_reg.cnt == tdc_pkg::CNT_ZERO)
		else $error("no wrap");
	count_step_a: assert property ( // R1
		tick && !ovf && !cap_mode && !wr
		|=> st_reg.cnt == $past(st_reg.cnt) + 8'h01)
		else $error("bad step");
	hold_count_a: assert property ( // R1
		!tick && !(cap_mode && edge_hit) && !wr
		|=> st_reg.cnt == $past(st_reg.cnt))
		else $error("spurious count");
	irq_overflow_a: assert property ( // R2
		!cap_mode && ovf && !st_reg.stop
		|=> st_reg.irq)
		else $error("overflow flag missing");
	low_write_a: assert property ( // R21
		wr && PADDR[11:2] == tdc_pkg::IDX_CNT_LO[9:0] && !tick && !(cap_mode && edge_hit)
		|=> st_reg.cnt == $past(st_reg.cnt))
		else $error("low write moved count");
	high_load_a: assert property ( // R21
		wr && PADDR[11:2] == tdc_pkg::IDX_CNT_HI[9:0]
		|=> st_reg.cnt == {$past(PWDATA[3:0]), $past(st_reg.load_lo)})
		else $error("high write did not load");

	// Capture checks
	capture_copy_a: assert property ( // R11
		cap_mode && edge_hit && !wr && !st_reg.stop
		|=> st_reg.rd == $past(st_reg.cnt) && st_reg.csf && st_reg.irq)
		else $error("capture failed");
	capture_restart_a: assert property ( // R11
		cap_mode && edge_hit && !tick && !wr
		|=> st_reg.cnt == tdc_pkg::CNT_ZERO)
		else $error("capture kept count");
	capture_error_a: assert property ( // R12
		cap_mode && st_reg.csf && edge_hit
		|=> st_reg.cef)
		else $error("no error flag");
	error_overflow_a: assert property ( // R12
		cap_mode && st_reg.csf && ovf
		|=> st_reg.cef)
		else $error("no error flag on overflow");
	capture_clear_a: assert property ( // R14
		wr && PADDR[11:2] == tdc_pkg::IDX_MODE2[9:0] && PWDATA[tdc_pkg::MODE2_CAPTURE_BIT] && !cap_mode
		|=> st_reg.cnt == tdc_pkg::CNT_ZERO)
		else $error("capture entry kept count");
	capture_pin_a: assert property ( // R14
		cap_mode
		|=> !TIMER_OUTPUT_EN)
		else $error("pin driven in capture");

	// Pin checks
	port_pin_a: assert property ( // R8
		st_reg.mode2 == tdc_pkg::OUT_PORT
		|=> !TIMER_OUTPUT_EN)
		else $error("pin driven in port mode");
	low_pin_a: assert property ( // R8
		st_reg.mode2 == tdc_pkg::OUT_LOW
		|=> !TIMER_OUTPUT_PIN && TIMER_OUTPUT_EN)
		else $error("low output wrong");
	high_pin_a: assert property ( // R8
		st_reg.mode2 == tdc_pkg::OUT_HIGH
		|=> TIMER_OUTPUT_PIN && TIMER_OUTPUT_EN)
		else $error("high output wrong");
	toggle_out_a: assert property ( // R9
		st_reg.mode2 == tdc_pkg::OUT_TOGGLE && st_reg.toe && ovf
		|=> TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN))
		else $error("no toggle");
	pwm_pin_a: assert property ( // R9
		st_reg.mode2 == tdc_pkg::OUT_PWM
		|=> TIMER_OUTPUT_PIN == (st_reg.cnt == tdc_pkg::CNT_MAX))
		else $error("pwm level wrong");

	// Register checks
	stop_clear_a: assert property ( // R15
		st_reg.stop
		|=> st_reg.mode1 == tdc_pkg::NIB_ZERO && st_reg.mode2 == tdc_pkg::NIB_ZERO && !st_reg.irq)
		else $error("stop kept modes");
	stop_pins_a: assert property ( // R15
		st_reg.stop
		|=> !st_reg.pinsel[tdc_pkg::PIN_EVENT_BIT] && st_reg.edge_sel == tdc_pkg::NIB_ZERO)
		else $error("stop kept pin setup");
	mode1_space_a: assert property ( // R16
		$changed(st_reg.mode1) && !st_reg.stop
		|=> !$changed(st_reg.mode1))
		else $error("mode1 too fast");
	irq_clear_a: assert property ( // R4
		wr && PADDR[11:2] == tdc_pkg::IDX_FLAGS[9:0] && !PWDATA[tdc_pkg::FLAG_IRQ_BIT] && !irq_set
		|=> !st_reg.irq)
		else $error("irq not cleared");
	flag_clear_a: assert property ( // R13
		wr && PADDR[11:2] == tdc_pkg::IDX_FLAGS[9:0] && !PWDATA[tdc_pkg::FLAG_CSF_BIT]
		&& !PWDATA[tdc_pkg::FLAG_CEF_BIT] && !cap_set && !err_set
		|=> !st_reg.csf && !st_reg.cef)
		else $error("capture flags not cleared");
	hi_latch_a: assert property ( // R22
		PSEL && !PENABLE && !PWRITE && PADDR[11:2] == tdc_pkg::IDX_CNT_HI[9:0] && !st_reg.cap_valid
		|=> st_reg.rd_lo_latch == $past(st_reg.cnt[3:0]))
		else $error("low nibble not latched");
	apb_answer_a: assert property ( // R1
		PSEL && !PENABLE
		|=> PREADY)
		else $error("no ready");

	// Coverage
	cover_overflow_c: cover property (ovf && st_reg.mode1[tdc_pkg::MODE1_RELOAD_BIT]);
	cover_capture_c: cover property (cap_mode && edge_hit);
	cover_error_c: cover property (st_reg.cef);
	cover_event_c: cover property (st_reg.mode1[2:0] == tdc_pkg::CLK_EVENT && tick);
	cover_pwm_c: cover property (st_reg.mode2 == tdc_pkg::OUT_PWM && TIMER_OUTPUT_PIN);
endmodule

// ### tdc_event_src.sv
// Event source model that drives the event/trigger pin from outside.
// Assumes the bench calls pulse() just after a rising clock edge.
`timescale 1ns/1ns
module tdc_event_src (
	input wire logic clk,
	output logic pin
);
	initial pin = 1'b0;
	// One high then low pulse, each level held hold+2 cycles
	task automatic pulse(input int hold);
		pin <= 1'b1;
		repeat (hold + 2) @(posedge clk);
		pin <= 1'b0;
		repeat (hold + 2) @(posedge clk);
	endtask
endmodule

// ### tdc_timer_tb_top.sv
// Testbench: APB register traffic, output modes, event counting, reload and capture.
// Assumes tdc_timer behind a zero-wait APB slave and tdc_event_src on the event pin.
`timescale 1ns/1ns
module tdc_timer_tb_top;
	typedef struct packed {logic [11:0] a; logic w; logic [3:0] d; logic [3:0] x; logic e;} tdc_row_s;
	logic clk, pready, pslverr, evp, opin, oen, irq, e, tg;
	logic rstn, psel, pen, pwr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int num_errors, n_checks, i;
	tdc_row_s rows [7];
	logic [3:0] om [5];
	logic [1:0] ox [5];
	tdc_timer dut (.SYS_CLK(clk), .RESETN(rstn), .PADDR(paddr), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVENT_TRIGGER_PIN(evp),
		.TIMER_OUTPUT_PIN(opin), .TIMER_OUTPUT_EN(oen), .TIMER_IRQ_FLAG(irq));
	tdc_event_src ev (.clk(clk), .pin(evp));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [11:0] a, input logic w, input logic [3:0] d);
		@(posedge clk);
		paddr <= a;
		pwr <= w;
		pwdata <= {28'h0000000, d};
		psel <= 1'b1;
		@(posedge clk);
		pen <= 1'b1;
		do @(negedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [3:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [3:0] x);
		apb(a, 1'b0, 4'h0);
		chk(r, {28'h0000000, x});
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		num_errors++;
		report_and_stop;
	end
	initial begin
		rows = '{'{12'h054, 1'b1, 4'h7, 4'h0, 1'b0}, '{12'h054, 1'b0, 4'h0, 4'h7, 1'b0},
			'{12'h040, 1'b0, 4'h0, 4'h0, 1'b0}, '{12'h094, 1'b0, 4'h0, 4'h0, 1'b0},
			'{12'h3FC, 1'b0, 4'h0, 4'h0, 1'b1}, '{12'h3FC, 1'b1, 4'h0, 4'h0, 1'b1},
			'{12'h054, 1'b1, 4'h0, 4'h0, 1'b0}};
		om = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h7};
		ox = '{2'b00, 2'b01, 2'b11, 2'b00, 2'b01};
		rstn <= 1'b0;
		psel <= 1'b0;
		pen <= 1'b0;
		pwr <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h00000000;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(12'h054, 4'h0);
		chk({30'h0, oen, irq}, 32'h0);
		for (i = 0; i < 7; i++) begin
			apb(rows[i].a, rows[i].w, rows[i].d);
			if (!rows[i].w && !rows[i].e) chk(r, {28'h0000000, rows[i].x});
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		wr(12'h054, 4'h3);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(12'h054, 4'h0);
		for (i = 0; i < 5; i++) begin
			wr(12'h054, om[i]);
			repeat (2) @(posedge clk);
			chk({30'h0, opin, oen}, {30'h0, ox[i]});
		end
		wr(12'h0C0, 4'h1);
		wr(12'h0C0, 4'h0);
		rd(12'h054, 4'h0);
		wr(12'h054, 4'h1);
		wr(12'h094, 4'h2);
		wr(12'h09C, 4'h8);
		wr(12'h040, 4'h7);
		repeat (3) @(posedge clk);
		wr(12'h044, 4'hE);
		wr(12'h048, 4'hF);
		rd(12'h048, 4'hF);
		rd(12'h044, 4'hE);
		ev.pulse(3);
		rd(12'h048, 4'hF);
		rd(12'h044, 4'hF);
		tg = opin;
		ev.pulse(3);
		chk({30'h0, irq, opin}, {30'h0, 1'b1, ~tg});
		rd(12'h048, 4'h0);
		rd(12'h044, 4'h0);
		wr(12'h084, 4'h0);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(12'h09C, 4'hC);
		ev.pulse(3);
		rd(12'h048, 4'h0);
		rd(12'h044, 4'h2);
		wr(12'h040, 4'hF);
		repeat (3) @(posedge clk);
		wr(12'h048, 4'hF);
		ev.pulse(3);
		rd(12'h048, 4'hF);
		rd(12'h044, 4'hE);
		wr(12'h09C, 4'h8);
		wr(12'h040, 4'h6);
		repeat (3) @(posedge clk);
		wr(12'h054, 4'h8);
		wr(12'h084, 4'h0);
		chk({31'h0, oen}, 32'h0);
		rd(12'h048, 4'h0);
		ev.pulse(3);
		rd(12'h084, 4'h3);
		ev.pulse(3);
		rd(12'h084, 4'h7);
		apb(12'h044, 1'b0, 4'h0);
		chk({31'h0, r[3:0] >= 4'h4 && r[3:0] <= 4'h9}, 32'h1);
		rd(12'h048, 4'h0);
		wr(12'h084, 4'h0);
		rd(12'h084, 4'h0);
		report_and_stop;
	end
endmodule
